// ===== sac_cmd.sv
`timescale 1ns/100ps
module sac_cmd
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  input wire logic slot_16_i,
  input wire logic cache_present_i,
  output logic read_start_o,
  output logic [31:0] read_lba_o,
  output logic [15:0] read_count_o,
  output logic [31:0] read_bytes_o,
  input wire logic read_done_i,
  input wire logic [7:0] read_err_i,
  output logic cmd_busy_o
);

  typedef struct packed {
    sac_state_e st;
    logic ack;
    logic err;
    logic [31:0] rdat;
    logic [15:0] cmd;
    logic [3:0] dev;
    logic [15:0] blocks;
    logic [15:0] blen;
    logic [31:0] lba;
    logic [7:0] pos2;
    logic [7:0] pos3;
    logic [7:0] pos4;
    logic [7:0] pacing;
    logic [15:0] cache_dis;
    logic [15:0] retry_dis;
    logic [31:0] cap_lba;
    logic [31:0] cap_len;
    logic [7:0] hit;
    logic [3:0] cflags;
    logic [7:0] dev_err;
    logic [7:0] cmd_err;
    logic [31:0] last_cb;
    logic [31:0] cb_addr;
    logic start;
    logic [143:0] result;
  } sac_cmd_s;

  sac_cmd_s q;
  sac_cmd_s d;
  logic acc;
  logic wr;
  logic [4:0] ra;
  logic [31:0] bytes;
  logic [7:0] hit_bcd;
  logic [15:0] wa;

  ////////////////////////////////////////////////////////////////////////
  // Combinational helpers
  assign acc = cyc_i && stb_i && !q.ack && !q.err;
  assign wr = acc && we_i;
  assign ra = adr_i[6:2];
  assign bytes = 32'(q.blocks) * 32'(q.blen);
  assign hit_bcd = (q.hit == SAC_HIT_FULL || q.hit[3:0] > 4'h9 ||
    q.hit[7:4] > 4'h9) ? SAC_HIT_FULL : q.hit;
  always_comb begin
    wa = 16'h0000;
    wa[15:12] = q.cflags;
    wa[SAC_CACHE_PRESENT_BIT] = cache_present_i;
    wa[7:0] = hit_bcd;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    d.start = 1'b0;
    if (acc) begin
      d.ack = 1'b1;
      d.rdat = 32'h0000_0000;
      case (ra)
        SAC_ADR_CMD: begin
          if (wr && q.st != SAC_BUSY) begin
            if (sel_i[1] && sel_i[0]) begin
              d.cmd = dat_i[15:0];
            end
            if (sel_i[2]) begin
              d.dev = dat_i[19:16];
            end
            d.st = SAC_BUSY;
          end
          d.rdat = {12'h000, q.dev, q.cmd};
        end
        SAC_ADR_LIMITS: begin
          if (wr) begin
            d.blocks = dat_i[15:0];
            d.blen = dat_i[31:16];
          end
          d.rdat = {q.blen, q.blocks};
        end
        SAC_ADR_POS23: begin
          if (wr) begin
            d.pos2 = dat_i[15:8];
            d.pos3 = dat_i[7:0];
          end
          d.rdat = {16'h0000, q.pos2, q.pos3};
        end
        SAC_ADR_POS4: begin
          if (wr) begin
            d.pos4 = dat_i[7:0];
          end
          d.rdat = {24'h000000, q.pos4};
        end
        SAC_ADR_PACING: begin
          if (wr) begin
            d.pacing = dat_i[7:0];
          end
          d.rdat = {24'h000000, q.pacing};
        end
        SAC_ADR_MASKS: begin
          if (wr) begin
            d.cache_dis = dat_i[15:0];
            d.retry_dis = dat_i[31:16];
          end
          d.rdat = {q.retry_dis, q.cache_dis};
        end
        SAC_ADR_CAP_LBA: begin
          if (wr) begin
            d.cap_lba = dat_i;
          end
          d.rdat = q.cap_lba;
        end
        SAC_ADR_CAP_LEN: begin
          if (wr) begin
            d.cap_len = dat_i;
          end
          d.rdat = q.cap_len;
        end
        SAC_ADR_CACHE: begin
          if (wr) begin
            d.hit = dat_i[7:0];
            d.cflags = dat_i[15:12];
          end
          d.rdat = {16'h0000, wa};
        end
        SAC_ADR_ERRS: begin
          d.rdat = {16'h0000, q.cmd_err, q.dev_err};
        end
        SAC_ADR_BLK: begin
          if (wr) begin
            d.lba = dat_i;
          end
          d.rdat = q.lba;
        end
        SAC_ADR_STAT: begin
          if (wr) begin
            d.cb_addr = dat_i;
          end
          d.rdat = q.cb_addr;
        end
        SAC_ADR_LAST_CB: begin
          d.rdat = q.last_cb;
        end
        SAC_ADR_STATUS: begin
          d.rdat = {30'h0, q.st};
        end
        default: begin
          if (ra >= SAC_ADR_RESULT &&
              ra < SAC_ADR_RESULT + 5'(SAC_RESULT_DEPTH)) begin
            d.rdat = {16'h0000, q.result[16*(ra-SAC_ADR_RESULT) +: 16]};
          end else begin
            d.ack = 1'b0;
            d.err = 1'b1;
          end
        end
      endcase
    end
    case (q.st)
      SAC_IDLE: begin
      end
      SAC_BUSY: begin
        d.last_cb = q.cb_addr;
        if (q.cmd == SAC_CMD_INFO) begin
          d.result[15:0] = SAC_ADAPTER_ID;
          d.result[31:16] = {q.pos2, q.pos3};
          d.result[47:32] = {q.pos4, SAC_INT_LEVEL};
          d.result[63:48] = {slot_16_i ? SAC_SLOT_16 : SAC_SLOT_32,
            12'h000};
          d.result[79:64] = {SAC_NUM_PHYS, SAC_NUM_LUNS};
          d.result[95:80] = {SAC_NUM_LDN, q.pacing};
          d.result[111:96] = {SAC_BUSY_SECONDS, SAC_EOI_USEC};
          d.result[127:112] = q.cache_dis;
          d.result[143:128] = q.retry_dis;
          d.cmd_err = SAC_ERR_NONE;
          d.dev_err = SAC_ERR_NONE;
          d.st = SAC_DONE;
        end else if ((q.cmd & SAC_CMD_CAP_MASK) == SAC_CMD_CAP) begin
          d.result = '0;
          d.result[15:0] = {q.cap_lba[31:24], q.cap_lba[23:16]};
          d.result[31:16] = {q.cap_lba[15:8], q.cap_lba[7:0]};
          d.result[47:32] = {q.cap_len[31:24], q.cap_len[23:16]};
          d.result[63:48] = {q.cap_len[15:8], q.cap_len[7:0]};
          d.cmd_err = SAC_ERR_NONE;
          d.dev_err = SAC_ERR_NONE;
          d.st = SAC_DONE;
        end else if ((q.cmd & SAC_CMD_READ_MASK) == SAC_CMD_READ) begin
          if (q.blocks == 16'h0000 || bytes > SAC_MAX_BYTES) begin
            d.cmd_err = SAC_CMD_ERR_LIMIT;
            d.dev_err = SAC_ERR_NONE;
            d.st = SAC_DONE;
          end else if (!q.start && read_done_i) begin
            d.dev_err = read_err_i;
            d.cmd_err = SAC_ERR_NONE;
            d.st = SAC_DONE;
          end
        end else begin
          d.cmd_err = SAC_CMD_ERR_BADCMD;
          d.st = SAC_DONE;
        end
      end
      SAC_DONE: begin
        d.st = SAC_IDLE;
      end
      default: begin
        d.st = SAC_IDLE;
      end
    endcase
    if (acc && wr && ra == SAC_ADR_CMD && q.st != SAC_BUSY &&
        ((dat_i[15:0] & SAC_CMD_READ_MASK) == SAC_CMD_READ)) begin
      d.start = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= SAC_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign dat_o = q.rdat;
  assign ack_o = q.ack;
  assign err_o = q.err;
  assign read_start_o = q.start && q.blocks != 16'h0000 &&
    bytes <= SAC_MAX_BYTES;
  assign read_lba_o = q.lba;
  assign read_count_o = q.blocks;
  assign read_bytes_o = bytes;
  assign cmd_busy_o = (q.st == SAC_BUSY);

endmodule : sac_cmd

// ===== sac_cmd_asserts.sv
`timescale 1ns/100ps
module sac_cmd_asserts
  import sac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  input wire logic slot_16_i,
  input wire logic cache_present_i,
  input wire logic read_start_o,
  input wire logic [15:0] read_count_o,
  input wire logic [31:0] read_bytes_o,
  input wire logic cmd_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic info;
  wire tk = cyc_i & stb_i & ~ack_o & ~err_o;
  wire cw = tk & we_i & adr_i == 8'h00 & ~cmd_busy_o;
  wire ri = tk & ~we_i & info & ~cmd_busy_o;
  // Info result valid since last accepted command
  always_ff @(posedge clk_i) begin
    if (rst_i) info <= 1'h0;
    else if (cw) info <= dat_i[15:0] == 16'h1c0a;
  end
  //////////////////////////////////////////////////////////////////////
  property p_id;
    ri && adr_i == 8'h40 |=> dat_o[15:0] == SAC_ADAPTER_ID;
  endproperty
  a_id: assert property (p_id)
    else $error("bad id word");
  property p_irq;
    ri && adr_i == 8'h48 |=> dat_o[7:0] == 8'h0e;
  endproperty
  a_irq: assert property (p_irq)
    else $error("bad level");
  property p_slot;
    ri && adr_i == 8'h4c |=> dat_o[15:12] == {3'h0, slot_16_i};
  endproperty
  a_slot: assert property (p_slot)
    else $error("bad slot size");
  property p_units;
    ri && adr_i == 8'h50 |=> dat_o[15:0] == 16'h0708;
  endproperty
  a_units: assert property (p_units)
    else $error("bad unit counts");
  property p_ldn;
    ri && adr_i == 8'h54 |=> dat_o[15:8] == 8'h10;
  endproperty
  a_ldn: assert property (p_ldn)
    else $error("bad device count");
  property p_times;
    ri && adr_i == 8'h58 |=> dat_o[15:0] == 16'h1e01;
  endproperty
  a_times: assert property (p_times)
    else $error("bad times");
  property p_cache;
    tk && !we_i && adr_i == 8'h20 |=> dat_o[11] == $past(cache_present_i);
  endproperty
  a_cache: assert property (p_cache)
    else $error("bad cache bit");
  property p_lim;
    read_start_o |-> read_count_o != 16'h0 && read_bytes_o <= 32'hff_ffff;
  endproperty
  a_lim: assert property (p_lim)
    else $error("read over limit");
endmodule : sac_cmd_asserts
bind sac_cmd sac_cmd_asserts chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .dat_i, .dat_o, .ack_o, .err_o, .slot_16_i, .cache_present_i,
  .read_start_o, .read_count_o, .read_bytes_o, .cmd_busy_o);

// ===== sac_pkg.sv
package sac_pkg;
  localparam logic [15:0] SAC_CMD_INFO = 16'h1c0a;
  localparam logic [15:0] SAC_CMD_CAP_MASK = 16'hff3f;
  localparam logic [15:0] SAC_CMD_CAP = 16'h1c09;
  localparam logic [15:0] SAC_CMD_READ_MASK = 16'hff3f;
  localparam logic [15:0] SAC_CMD_READ = 16'h1c01;
  localparam logic [7:0] SAC_INFO_WORDS = 8'h09;
  localparam logic [7:0] SAC_CAP_BYTES = 8'h08;
  localparam logic [15:0] SAC_ADAPTER_ID = 16'h5a3c;
  localparam logic [7:0] SAC_INT_LEVEL = 8'h0e;
  localparam logic [3:0] SAC_SLOT_32 = 4'h0;
  localparam logic [3:0] SAC_SLOT_16 = 4'h1;
  localparam logic [7:0] SAC_NUM_PHYS = 8'h07;
  localparam logic [7:0] SAC_NUM_LUNS = 8'h08;
  localparam logic [7:0] SAC_NUM_LDN = 8'h10;
  localparam logic [7:0] SAC_BUSY_SECONDS = 8'h1e;
  localparam logic [7:0] SAC_EOI_USEC = 8'h01;
  localparam logic [7:0] SAC_HIT_FULL = 8'ha0;
  localparam int SAC_CACHE_PRESENT_BIT = 11;
  localparam logic [15:0] SAC_MAX_BLOCKS = 16'hffff;
  localparam logic [31:0] SAC_MAX_BYTES = 32'h00ff_ffff;
  localparam logic [7:0] SAC_RD_OK = 8'h00;
  localparam logic [7:0] SAC_ERR_NONE = 8'h00;
  localparam logic [7:0] SAC_ERR_RESET = 8'h01;
  localparam logic [7:0] SAC_ERR_IFACE = 8'h02;
  localparam logic [7:0] SAC_ERR_SEL_TO = 8'h10;
  localparam logic [7:0] SAC_ERR_BUS_FREE = 8'h11;
  localparam logic [7:0] SAC_ERR_PHASE = 8'h13;
  localparam logic [7:0] SAC_ERR_SHORT = 8'h20;
  localparam logic [7:0] SAC_CMD_ERR_LIMIT = 8'h0b;
  localparam logic [7:0] SAC_CMD_ERR_BADCMD = 8'h03;
  localparam logic [4:0] SAC_ADR_CMD = 5'h00;
  localparam logic [4:0] SAC_ADR_LIMITS = 5'h01;
  localparam logic [4:0] SAC_ADR_POS23 = 5'h02;
  localparam logic [4:0] SAC_ADR_POS4 = 5'h03;
  localparam logic [4:0] SAC_ADR_PACING = 5'h04;
  localparam logic [4:0] SAC_ADR_MASKS = 5'h05;
  localparam logic [4:0] SAC_ADR_CAP_LBA = 5'h06;
  localparam logic [4:0] SAC_ADR_CAP_LEN = 5'h07;
  localparam logic [4:0] SAC_ADR_CACHE = 5'h08;
  localparam logic [4:0] SAC_ADR_ERRS = 5'h09;
  localparam logic [4:0] SAC_ADR_BLK = 5'h0a;
  localparam logic [4:0] SAC_ADR_STAT = 5'h0b;
  localparam logic [4:0] SAC_ADR_LAST_CB = 5'h0c;
  localparam logic [4:0] SAC_ADR_STATUS = 5'h0d;
  localparam logic [4:0] SAC_ADR_RESULT = 5'h10;
  localparam logic [3:0] SAC_RESULT_DEPTH = 4'h9;
  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_BUSY = 2'b01,
    SAC_DONE = 2'b10
  } sac_state_e;
endpackage : sac_pkg

// ===== sac_scsi_model.sv
`timescale 1ns/100ps
module sac_scsi_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] code_i,
  input wire logic [3:0] dly_i,
  output logic done_o,
  output logic [7:0] err_o
);
  logic [3:0] cnt;
  logic run;
  // Finish a read dly_i cycles after start (16 cycles when dly_i is 0)
  always_ff @(posedge clk_i) begin
    done_o <= 1'h0;
    if (rst_i) begin
      run <= 1'h0;
      cnt <= 4'h0;
    end else if (start_i) begin
      run <= 1'h1;
      cnt <= dly_i;
    end else if (run) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        run <= 1'h0;
        done_o <= 1'h1;
      end
    end
  end
  // Stale code hidden outside the pulse
  assign err_o = done_o ? code_i : ~code_i;
endmodule : sac_scsi_model

// ===== scsi_adapter_status_and_info_cmds_test.sv
`timescale 1ns/100ps
module scsi_adapter_status_and_info_cmds_test
  import sac_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0;
  logic stb_i = 1'h0;
  logic we_i = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic slot_16_i = 1'h1;
  logic cache_present_i = 1'h1;
  logic [7:0] code = 8'h00;
  logic [3:0] dly = 4'h1;
  logic [31:0] dat_o, read_lba_o, read_bytes_o, rd;
  logic ack_o, err_o, read_start_o, read_done_i, cmd_busy_o, be;
  logic [15:0] read_count_o;
  logic [7:0] read_err_i;
  logic [7:0] codes [7] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h11, 8'h13, 8'h20};
  int err_count = 0;
  int checked = 0;
  int starts = 0;
  logic [31:0] lba_s = 32'h0;
  logic [31:0] bytes_s = 32'h0;
  logic [15:0] cnt_s = 16'h0;
  initial forever #25 clk_i = ~clk_i;
  // Count read starts, keep the parameters they carry
  always @(posedge clk_i) begin
    if (read_start_o === 1'h1) begin
      starts++;
      lba_s = read_lba_o;
      bytes_s = read_bytes_o;
      cnt_s = read_count_o;
    end
  end
  sac_cmd uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
    .dat_i, .dat_o, .ack_o, .err_o, .slot_16_i, .cache_present_i,
    .read_start_o, .read_lba_o, .read_count_o, .read_bytes_o,
    .read_done_i, .read_err_i, .cmd_busy_o);
  sac_scsi_model mdl (.clk_i, .rst_i, .start_i(read_start_o),
    .code_i(code), .dly_i(dly), .done_o(read_done_i), .err_o(read_err_i));
  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'h1 && err_o !== 1'h1 && n < 20);
    rd = dat_o;
    be = err_o;
    if (n == 20) begin
      err_count++;
      test_done;
    end
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask : wb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    wb(1'h0, a, 32'h0);
    chk(rd & m, e);
  endtask : rdc
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      wb(1'h0, 8'h34, 32'h0);
      n++;
    end while (rd[1:0] === 2'h1 && n < 60);
    if (n == 60) begin
      err_count++;
      test_done;
    end
  endtask : wait_idle
  //////////////////////////////////////////////////////////////////////
  task automatic t_info(input logic s);
    slot_16_i <= s;
    wb(1'h1, 8'h08, 32'hab12);
    wb(1'h1, 8'h0c, 32'h5c);
    wb(1'h1, 8'h10, 32'h37);
    wb(1'h1, 8'h14, 32'h1234_8001);
    wb(1'h1, 8'h00, 32'h1c0a);
    wait_idle;
    rdc(8'h40, {16'h0, SAC_ADAPTER_ID}, 32'hffff);
    rdc(8'h44, 32'hab12, 32'hffff);
    rdc(8'h48, 32'h5c0e, 32'hffff);
    rdc(8'h4c, {16'h0, 3'h0, s, 12'h0}, 32'hf000);
    rdc(8'h50, 32'h0708, 32'hffff);
    rdc(8'h54, 32'h1037, 32'hffff);
    rdc(8'h58, 32'h1e01, 32'hffff);
    rdc(8'h5c, 32'h8001, 32'hffff);
    rdc(8'h60, 32'h1234, 32'hffff);
  endtask : t_info
  task automatic t_cap;
    wb(1'h1, 8'h18, 32'h0012_3456);
    wb(1'h1, 8'h1c, 32'h0200);
    wb(1'h1, 8'h00, 32'h0003_1cc9);
    wait_idle;
    rdc(8'h40, 32'h0012, 32'hffff);
    rdc(8'h44, 32'h3456, 32'hffff);
    rdc(8'h48, 32'h0000, 32'hffff);
    rdc(8'h4c, 32'h0200, 32'hffff);
  endtask : t_cap
  task automatic t_read(input logic [15:0] cnt, input logic [15:0] len,
      input logic [7:0] c, input logic [7:0] ce);
    int s0;
    s0 = starts;
    code <= c;
    dly <= dly + 4'h5;
    wb(1'h1, 8'h04, {len, cnt});
    wb(1'h1, 8'h28, 32'h0004_0000 + c);
    wb(1'h1, 8'h2c, 32'h8765_4320 + c);
    wb(1'h1, 8'h00, 32'h1c01);
    chk({31'h0, cmd_busy_o}, 32'h1);
    wait_idle;
    chk(starts - s0, {31'h0, ce == 8'h00});
    if (ce == 8'h00) begin
      chk(lba_s, 32'h0004_0000 + c);
      chk({16'h0, cnt_s}, {16'h0, cnt});
      chk(bytes_s, 32'(cnt) * 32'(len));
    end
    rdc(8'h24, {16'h0, ce, c}, ce == 8'h00 ? 32'hffff : 32'hff00);
    rdc(8'h30, 32'h8765_4320 + c, 32'hffff_ffff);
  endtask : t_read
  task automatic t_cache(input logic p, input logic [15:0] w,
      input logic [15:0] e);
    cache_present_i <= p;
    wb(1'h1, 8'h20, {16'h0, w});
    rdc(8'h20, {16'h0, e}, 32'hf8ff);
  endtask : t_cache
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    t_info(1'h1);
    t_info(1'h0);
    t_cap;
    foreach (codes[i]) t_read(16'h0010, 16'h0200, codes[i], 8'h00);
    t_read(16'h0000, 16'h0200, 8'h00, 8'h0b);
    t_read(16'hffff, 16'h0101, 8'h00, 8'h0b);
    t_read(16'hffff, 16'h0100, 8'h20, 8'h00);
    wb(1'h1, 8'h10, 32'h0);
    rdc(8'h24, 32'h0020, 32'hffff);
    wb(1'h1, 8'h00, 32'h0000_1c0f);
    wait_idle;
    rdc(8'h24, 32'h0300, 32'hff00);
    t_cache(1'h1, 16'h5099, 16'h5899);
    t_cache(1'h0, 16'ha0a0, 16'ha0a0);
    t_cache(1'h1, 16'h003c, 16'h08a0);
    wb(1'h0, 8'h38, 32'h0);
    chk({31'h0, be}, 32'h1);
    test_done;
  end
endmodule : scsi_adapter_status_and_info_cmds_test
